/* File: core/ext_int_detector.sv */
`default_nettype none
module ext_int_detector (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Configuration
  input  wire ext_int_pkg::control_type ctrl,
  // Pin and events
  input  wire logic              pin,
  output logic                   event_hit,
  output logic                   level_active
);
  import ext_int_pkg::*;

  logic pin_q;
  logic pin_d;
  logic active;

  // ************************************************************
  // Polarity normalised detection
  // ************************************************************
  assign active       = ctrl.polarity_select ? pin : ~pin;
  assign level_active = ctrl.pin_enable & ctrl.detect_mode & active;

  always_comb begin
    pin_d     = active;
    event_hit = 1'b0;
    if (ctrl.pin_enable) begin
      event_hit = active & ~pin_q;
      if (ctrl.detect_mode) begin
        event_hit = active;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= pin_d;
    end
  end

endmodule
`default_nettype wire

/* File: core/ext_int_pin_logic.sv */
`default_nettype none
module ext_int_pin_logic (
  // Clock and reset
  input  wire logic                        CLK_SYS,
  input  wire logic                        RESETN,
  // AXI4-Lite write address
  input  wire logic                        AWVALID,
  output logic                             AWREADY,
  input  wire logic [7:0]                  AWADDR,
  // AXI4-Lite write data
  input  wire logic                        WVALID,
  output logic                             WREADY,
  input  wire logic [31:0]                 WDATA,
  input  wire logic [3:0]                  WSTRB,
  // AXI4-Lite write response
  output logic                             BVALID,
  input  wire logic                        BREADY,
  output logic [1:0]                       BRESP,
  // AXI4-Lite read address
  input  wire logic                        ARVALID,
  output logic                             ARREADY,
  input  wire logic [7:0]                  ARADDR,
  // AXI4-Lite read data
  output logic                             RVALID,
  input  wire logic                        RREADY,
  output logic [31:0]                      RDATA,
  output logic [1:0]                       RRESP,
  // Request pin and pull control
  input  wire logic                        EXT_INT_PIN,
  output ext_int_pkg::pull_ctrl_type       PULL_CTRL,
  // Interrupts
  output logic                             CPU_IRQ,
  output logic                             EVENT_IRQ
);
  import ext_int_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  control_type   ctrl_q;
  control_type   ctrl_d;
  logic          flag_q;
  logic          flag_d;
  logic          sticky_q;
  logic          sticky_d;
  logic          mask_q;
  logic          mask_d;
  logic          aw_q;
  logic          aw_d;
  logic          w_q;
  logic          w_d;
  logic [7:0]    awaddr_q;
  logic [7:0]    awaddr_d;
  logic [31:0]   wdata_q;
  logic [31:0]   wdata_d;
  logic          wlane_q;
  logic          wlane_d;
  logic          bvalid_q;
  logic          bvalid_d;
  logic [1:0]    bresp_q;
  logic [1:0]    bresp_d;
  logic          rvalid_q;
  logic          rvalid_d;
  logic [31:0]   rdata_q;
  logic [31:0]   rdata_d;
  logic [1:0]    rresp_q;
  logic [1:0]    rresp_d;
  logic          event_hit;
  logic          level_active;
  logic          do_write;
  logic          do_read;
  logic          ack_write;
  logic [7:0]    status_byte;
  pull_ctrl_type pull_d;
  pull_ctrl_type pull_q;

  // ************************************************************
  // Detector
  // ************************************************************
  ext_int_detector u_detector (
    .clk          (CLK_SYS),
    .resetn       (RESETN),
    .ctrl         (ctrl_q),
    .pin          (EXT_INT_PIN),
    .event_hit    (event_hit),
    .level_active (level_active)
  );

  // ************************************************************
  // Bus handshakes
  // ************************************************************
  assign AWREADY  = ~aw_q & ~bvalid_q;
  assign WREADY   = ~w_q & ~bvalid_q;
  assign ARREADY  = ~rvalid_q;
  assign do_write = aw_q & w_q & ~bvalid_q;
  assign do_read  = ARVALID & ARREADY;
  assign ack_write = do_write & (awaddr_q == ADDR_STATUS_CONTROL) & wlane_q
                     & wdata_q[BIT_ACKNOWLEDGE];

  // Status byte, top bit and acknowledge read zero
  always_comb begin
    status_byte = 8'h00;
    status_byte[BIT_DETECT_MODE]     = ctrl_q.detect_mode;
    status_byte[BIT_REQUEST_ENABLE]  = ctrl_q.request_enable;
    status_byte[BIT_EVENT_FLAG]      = flag_q;
    status_byte[BIT_PIN_ENABLE]      = ctrl_q.pin_enable;
    status_byte[BIT_POLARITY_SELECT] = ctrl_q.polarity_select;
    status_byte[BIT_PULL_DISABLE]    = ctrl_q.pull_disable;
  end

  always_comb begin
    aw_d     = aw_q;
    w_d      = w_q;
    awaddr_d = awaddr_q;
    wdata_d  = wdata_q;
    wlane_d  = wlane_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    if (AWVALID && AWREADY) begin
      aw_d     = 1'b1;
      awaddr_d = AWADDR;
    end
    if (WVALID && WREADY) begin
      w_d     = 1'b1;
      wdata_d = WDATA;
      wlane_d = WSTRB[0];
    end
    if (do_write) begin
      aw_d     = 1'b0;
      w_d      = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = RESP_OKAY;
      if (awaddr_q != ADDR_STATUS_CONTROL && awaddr_q != ADDR_EVENT_STATUS && awaddr_q != ADDR_EVENT_MASK) begin
        bresp_d = RESP_SLVERR;
      end
    end else if (bvalid_q && BREADY) begin
      bvalid_d = 1'b0;
    end
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (do_read) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (ARADDR)
        ADDR_STATUS_CONTROL: rdata_d = {24'h000000, status_byte};
        ADDR_EVENT_STATUS:   rdata_d = {31'h00000000, sticky_q};
        ADDR_EVENT_MASK:     rdata_d = {31'h00000000, mask_q};
        default: begin
          rdata_d = READ_ZERO;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && RREADY) begin
      rvalid_d = 1'b0;
    end
  end

  // ************************************************************
  // Control, flag and interrupt state
  // ************************************************************
  always_comb begin
    ctrl_d   = ctrl_q;
    mask_d   = mask_q;
    flag_d   = flag_q;
    sticky_d = sticky_q;
    if (do_write && wlane_q && awaddr_q == ADDR_STATUS_CONTROL) begin
      ctrl_d.detect_mode     = wdata_q[BIT_DETECT_MODE];
      ctrl_d.request_enable  = wdata_q[BIT_REQUEST_ENABLE];
      ctrl_d.pin_enable      = wdata_q[BIT_PIN_ENABLE];
      ctrl_d.polarity_select = wdata_q[BIT_POLARITY_SELECT];
      ctrl_d.pull_disable    = wdata_q[BIT_PULL_DISABLE];
    end
    if (do_write && wlane_q && awaddr_q == ADDR_EVENT_MASK) begin
      mask_d = wdata_q[0];
    end
    if (ack_write && !level_active) begin
      flag_d = 1'b0;
    end
    if (do_read && ARADDR == ADDR_EVENT_STATUS) begin
      sticky_d = 1'b0;
    end
    if (event_hit) begin
      flag_d   = 1'b1;
      sticky_d = 1'b1;
    end
  end

  always_comb begin
    pull_d = '0;
    if (ctrl_q.pin_enable && !ctrl_q.pull_disable) begin
      pull_d.pull_down = ctrl_q.polarity_select;
      pull_d.pull_up   = ~ctrl_q.polarity_select;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q   <= control_type'(CONTROL_RESET[4:0]);
      mask_q   <= MASK_RESET;
      flag_q   <= 1'b0;
      sticky_q <= 1'b0;
      pull_q   <= '0;
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wlane_q  <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q  <= READ_ZERO;
      rresp_q  <= RESP_OKAY;
    end else begin
      ctrl_q   <= ctrl_d;
      mask_q   <= mask_d;
      flag_q   <= flag_d;
      sticky_q <= sticky_d;
      pull_q   <= pull_d;
      aw_q     <= aw_d;
      w_q      <= w_d;
      awaddr_q <= awaddr_d;
      wdata_q  <= wdata_d;
      wlane_q  <= wlane_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign BVALID    = bvalid_q;
  assign BRESP     = bresp_q;
  assign RVALID    = rvalid_q;
  assign RDATA     = rdata_q;
  assign RRESP     = rresp_q;
  assign PULL_CTRL = pull_q;
  assign CPU_IRQ   = flag_q & ctrl_q.request_enable;
  assign EVENT_IRQ = sticky_q & mask_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_ack_taken;
    ack_write && !level_active && !event_hit;
  endsequence

  a_flag_sets: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    event_hit |=> flag_q) else $error("flag not set by event");
  a_ack_clears: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    s_ack_taken |=> !flag_q) else $error("acknowledge did not clear flag");
  a_level_holds: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (flag_q && level_active) |=> flag_q) else $error("flag cleared at asserted level");
  a_irq_follows: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (event_hit && ctrl_q.request_enable && !(do_write && awaddr_q == ADDR_STATUS_CONTROL)) |=> CPU_IRQ)
    else $error("cpu request not raised");
  a_pin_disabled: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (!ctrl_q.pin_enable && !flag_q) |=> !flag_q) else $error("flag set with pin disabled");
  a_pull_polarity: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    $past(ctrl_q.pin_enable && !ctrl_q.pull_disable) |-> PULL_CTRL.pull_down == $past(ctrl_q.polarity_select)
    && PULL_CTRL.pull_up == !$past(ctrl_q.polarity_select)) else $error("pull direction wrong");
  a_pull_off: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    $past(ctrl_q.pull_disable) |-> PULL_CTRL == '0) else $error("pull not disabled");
  a_top_zero: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (RVALID && !$past(RVALID)) |-> RDATA[7] == 1'b0 && RDATA[BIT_ACKNOWLEDGE] == 1'b0)
    else $error("reserved or acknowledge bit read nonzero");
  a_edge_only: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (ctrl_q.pin_enable && !ctrl_q.detect_mode && event_hit) |=> !event_hit || !$stable(ctrl_q))
    else $error("edge mode fired twice");
  a_rise_pol: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (event_hit && ctrl_q.polarity_select) |-> EXT_INT_PIN) else $error("rising polarity hit at low pin");

endmodule
`default_nettype wire

/* File: core/ext_int_pkg.sv */
`default_nettype none
package ext_int_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0]  ADDR_STATUS_CONTROL = 8'h00;
  localparam logic [7:0]  ADDR_EVENT_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_EVENT_MASK     = 8'h08;
  localparam logic [31:0] READ_ZERO           = 32'h0000_0000;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_DETECT_MODE     = 0;
  localparam int BIT_REQUEST_ENABLE  = 1;
  localparam int BIT_ACKNOWLEDGE     = 2;
  localparam int BIT_EVENT_FLAG      = 3;
  localparam int BIT_PIN_ENABLE      = 4;
  localparam int BIT_POLARITY_SELECT = 5;
  localparam int BIT_PULL_DISABLE    = 6;

  // ************************************************************
  // Reset values, write mask and responses
  // ************************************************************
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'h73;
  localparam logic [0:0] MASK_RESET    = 1'h0;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic pull_up;
    logic pull_down;
  } pull_ctrl_type;

  typedef struct packed {
    logic pull_disable;
    logic polarity_select;
    logic pin_enable;
    logic request_enable;
    logic detect_mode;
  } control_type;

endpackage
`default_nettype wire

/* File: test/ext_int_pin_logic_bench.sv */
`default_nettype none
module ext_int_pin_logic_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ext_int_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic          CLK_SYS, RESETN, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic          ARVALID, ARREADY, RVALID, RREADY, EXT_INT_PIN, CPU_IRQ, EVENT_IRQ;
  logic [7:0]    AWADDR, ARADDR;
  logic [31:0]   WDATA, RDATA;
  logic [3:0]    WSTRB;
  logic [1:0]    BRESP, RRESP;
  pull_ctrl_type PULL_CTRL;
  logic          src_en, src_val;
  int            n_fail, samples_checked, p, i;
  logic [7:0]    cfg;
  logic [7:0]    pull_cfg [4] = '{8'h10, 8'h30, 8'h50, 8'h20};
  logic [1:0]    pull_exp [4] = '{2'b10, 2'b01, 2'b00, 2'b00};

  ext_int_pin_logic dut (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID),
    .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .EXT_INT_PIN(EXT_INT_PIN), .PULL_CTRL(PULL_CTRL), .CPU_IRQ(CPU_IRQ), .EVENT_IRQ(EVENT_IRQ));

  ext_int_source_model source (.clk(CLK_SYS), .drive_en(src_en), .drive_val(src_val), .pull(PULL_CTRL),
    .pin(EXT_INT_PIN));

  initial begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = !CLK_SYS;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp = RESP_OKAY);
    logic b;
    logic [1:0] r;
    b = 1'b0;
    r = 2'h0;
    @(posedge CLK_SYS);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    // Each channel released at the edge that takes it
    while (!b) begin
      @(posedge CLK_SYS);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      b = BVALID;
      r = BRESP;
    end
    BREADY <= 1'b0;
    check("write response", {29'h0, 1'b1, rsp}, {29'h0, b, r});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rsp = RESP_OKAY);
    logic rv;
    logic [33:0] got;
    rv = 1'b0;
    got = '0;
    @(posedge CLK_SYS);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!rv) begin
      @(posedge CLK_SYS);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      rv = RVALID;
      got = {RRESP, RDATA};
    end
    RREADY <= 1'b0;
    check("read response", {29'h0, 1'b1, rsp}, {29'h0, rv, got[33:32]});
    check("read data", exp, got[31:0]);
  endtask

  task automatic drive(input logic v);
    @(posedge CLK_SYS);
    src_en <= 1'b1;
    src_val <= v;
    repeat (4) @(posedge CLK_SYS);
  endtask

  task automatic done(input string name);
    $display("Test %s ended", name);
  endtask

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {RESETN, AWVALID, WVALID, BREADY, ARVALID, RREADY, src_val} = '0;
    {AWADDR, ARADDR, WDATA, n_fail, samples_checked} = '0;
    WSTRB = 4'hF;
    src_en = 1'b1;
    repeat (20) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    rd(ADDR_STATUS_CONTROL, READ_ZERO);
    rd(ADDR_EVENT_MASK, READ_ZERO);
    rd(8'h0C, READ_ZERO, RESP_SLVERR);
    wr(8'h0C, 32'h0000_0001, RESP_SLVERR);
    done("reset and map");
    wr(ADDR_STATUS_CONTROL, 32'h0000_00FF);
    rd(ADDR_STATUS_CONTROL, 32'h0000_0073);
    check("pull off", 32'h0, PULL_CTRL);
    for (i = 0; i < 4; i++) begin
      wr(ADDR_STATUS_CONTROL, {24'h0, pull_cfg[i]});
      repeat (2) @(posedge CLK_SYS);
      check("pull select", {30'h0, pull_exp[i]}, PULL_CTRL);
    end
    done("control and pull");
    for (p = 0; p < 2; p++) begin
      cfg = {2'b00, p[0], 2'b10, 1'b0, !p[0], 1'b0};
      drive(!p[0]);
      wr(ADDR_STATUS_CONTROL, {24'h0, cfg | 8'h04});
      rd(ADDR_STATUS_CONTROL, {24'h0, cfg});
      drive(p[0]);
      rd(ADDR_STATUS_CONTROL, {24'h0, cfg | 8'h08});
      check("cpu request", {31'h0, !p[0]}, CPU_IRQ);
      wr(ADDR_STATUS_CONTROL, {24'h0, cfg});
      rd(ADDR_STATUS_CONTROL, {24'h0, cfg | 8'h08});
      wr(ADDR_STATUS_CONTROL, {24'h0, cfg | 8'h04});
      rd(ADDR_STATUS_CONTROL, {24'h0, cfg});
      check("cpu request off", 32'h0, CPU_IRQ);
      drive(!p[0]);
    end
    done("edge detection");
    wr(ADDR_STATUS_CONTROL, 32'h0000_0004);
    drive(1'b0);
    drive(1'b1);
    drive(1'b0);
    rd(ADDR_STATUS_CONTROL, READ_ZERO);
    done("pin disabled");
    drive(1'b1);
    wr(ADDR_STATUS_CONTROL, 32'h0000_0017);
    drive(1'b0);
    wr(ADDR_STATUS_CONTROL, 32'h0000_0017);
    rd(ADDR_STATUS_CONTROL, 32'h0000_001B);
    check("cpu request level", 32'h1, CPU_IRQ);
    drive(1'b1);
    wr(ADDR_STATUS_CONTROL, 32'h0000_0017);
    rd(ADDR_STATUS_CONTROL, 32'h0000_0013);
    done("level detection");
    rd(ADDR_EVENT_STATUS, 32'h0000_0001);
    rd(ADDR_EVENT_STATUS, READ_ZERO);
    wr(ADDR_EVENT_MASK, 32'h0000_0001);
    rd(ADDR_EVENT_MASK, 32'h0000_0001);
    drive(1'b0);
    drive(1'b1);
    check("event irq", 32'h1, EVENT_IRQ);
    rd(ADDR_EVENT_STATUS, 32'h0000_0001);
    check("event irq cleared", 32'h0, EVENT_IRQ);
    wr(ADDR_EVENT_MASK, READ_ZERO);
    drive(1'b0);
    drive(1'b1);
    check("event irq masked", 32'h0, EVENT_IRQ);
    rd(ADDR_EVENT_STATUS, 32'h0000_0001);
    src_en <= 1'b0;
    done("event status and mask");
    RESETN <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    rd(ADDR_STATUS_CONTROL, READ_ZERO);
    rd(ADDR_EVENT_STATUS, READ_ZERO);
    check("cpu request after reset", 32'h0, CPU_IRQ);
    check("pull after reset", 32'h0, PULL_CTRL);
    done("mid-run reset");
    summarize();
  end

  initial begin
    repeat (20000) @(posedge CLK_SYS);
    n_fail++;
    summarize();
  end
endmodule
`default_nettype wire

/* File: test/ext_int_source_model.sv */
`default_nettype none
module ext_int_source_model (
  // Clock and drive request
  input  wire logic                       clk,
  input  wire logic                       drive_en,
  input  wire logic                       drive_val,
  // Pull device and pin
  input  wire ext_int_pkg::pull_ctrl_type pull,
  output logic                            pin
);
  timeunit 1ns;
  timeprecision 1ns;
  import ext_int_pkg::*;

  // ****************************************
  // Pin level
  // ****************************************
  logic float_q = 1'b0;

  // Undriven, unpulled pin wanders every cycle
  always @(posedge clk) float_q <= !float_q;

  always_comb begin
    if (drive_en) pin = drive_val;
    else if (pull.pull_up) pin = 1'b1;
    else if (pull.pull_down) pin = 1'b0;
    else pin = float_q;
  end
endmodule
`default_nettype wire
